// ---- core/sbsc_sram_core.sv ----
// Synchronous burst SRAM core: array, burst control, byte writes and output pipeline.
// Assumes all control inputs are synchronous to clock except output enable and sleep.

`default_nettype none

module sbsc_sram_core
  import sbsc_pkg::*;
#(
  parameter int LANE_W = LANE_W_DEF,
  parameter int LANES = LANES_DEF,
  parameter int ADDR_W = ADDR_W_DEF
) (
  input wire logic clock, // System clock, rising edge.
  input wire logic rst, // Asynchronous reset, active high.
  input wire logic [ADDR_W-1:0] addr, // External address.
  input wire logic [LANE_W*LANES-1:0] dataIn, // Data pins as seen from outside.
  output logic [LANE_W*LANES-1:0] dataOut, // Data to drive onto the pins.
  output logic dataOe, // High while the core drives the data pins.
  input wire logic chipSelectN, // Chip select, active low.
  input wire logic procAddrStrobeN, // Processor address strobe, active low.
  input wire logic ctrlAddrStrobeN, // Controller address strobe, active low.
  input wire logic burstStepN, // Burst advance, active low.
  input wire logic [LANES-1:0] laneWriteN, // Per-lane write selects, active low.
  input wire logic laneWriteEnableN, // Lane write enable, active low.
  input wire logic allLanesWriteN, // Write every lane, active low.
  input wire logic outEnableN, // Output enable, active low, asynchronous.
  input wire logic sleepRequest, // Sleep request, active high, asynchronous.
  input wire logic flowthruStrapN, // Low for flow-through reads, high for pipelined.
  input wire logic linearOrderStrapN, // Low for linear order, high for interleaved.
  input wire logic singleDeselectStrap // High for single deselect, low for dual.
);

  localparam int DATA_W = LANE_W * LANES;
  localparam int DEPTH = 2 ** ADDR_W;

  typedef struct packed {
    logic active;
    logic [ADDR_W-1:BURST_W] upper;
    sbsc_op_t opFirst;
    logic rdSecond;
    logic [DATA_W-1:0] firstData;
    logic [DATA_W-1:0] secondData;
  } sbsc_core_state_t;

  sbsc_core_state_t state_reg;
  sbsc_core_state_t state_next;

  logic [DATA_W-1:0] memArray [DEPTH];

  sbsc_burst_if burst ();

  logic startCyc;
  logic selStart;
  logic deselCyc;
  logic contCyc;
  logic stepCyc;
  logic writeAllowed;
  logic isWrite;
  logic isRead;
  logic [LANES-1:0] wrLanes;
  logic [ADDR_W-1:0] effAddr;
  logic [BURST_W-1:0] effLow;
  logic [DATA_W-1:0] rdLookup;
  logic [LANE_W-1:0] laneZeroIn;
  logic flowMode;
  logic dualDeselectMode;
  logic driveWindow;

  // Cycle decode. Sleep blocks every new operation but keeps the array contents.
  assign startCyc = !sleepRequest && (!procAddrStrobeN || !ctrlAddrStrobeN);
  assign selStart = startCyc && !chipSelectN;
  assign deselCyc = startCyc && chipSelectN;
  assign contCyc = !sleepRequest && !startCyc && state_reg.active;
  assign stepCyc = contCyc && !burstStepN;

  // Lane selection; the all-lanes input overrides every lane control.
  always_comb begin
    if (!allLanesWriteN) begin
      wrLanes = '1;
    end else if (!laneWriteEnableN) begin
      wrLanes = ~laneWriteN;
    end else begin
      wrLanes = '0;
    end
  end

  // A processor strobe start is always a read; writes follow in later cycles.
  assign writeAllowed = (selStart && procAddrStrobeN) || contCyc;
  assign isWrite = writeAllowed && (|wrLanes);
  assign isRead = (selStart || contCyc) && !isWrite;

  // Burst counter hookup.
  assign burst.load = selStart;
  assign burst.step = stepCyc;
  assign burst.loadLow = addr[BURST_W-1:0];
  assign burst.linear = !linearOrderStrapN;

  sbsc_burst_counter u_counter (
    .clock(clock),
    .rst(rst),
    .burst(burst.cnt)
  );

  // A start uses the pin address; later cycles use the held upper bits and the counter.
  assign effAddr = selStart ? addr : {state_reg.upper, burst.low};
  assign effLow = effAddr[BURST_W-1:0];
  assign rdLookup = memArray[effAddr];
  assign laneZeroIn = dataIn[LANE_W-1:0];

  // Array write. The write lands on the capturing edge, so no external pulse is needed.
  always_ff @(posedge clock) begin
    for (int i = 0; i < LANES; i++) begin
      if (isWrite && wrLanes[i]) begin
        memArray[effAddr][i*LANE_W +: LANE_W] <= dataIn[i*LANE_W +: LANE_W];
      end
    end
  end

  // Next state: burst context, captured operation and the two read data stages.
  always_comb begin
    state_next = state_reg;
    if (selStart) begin
      state_next.active = 1'h1;
      state_next.upper = addr[ADDR_W-1:BURST_W];
    end else if (deselCyc) begin
      state_next.active = 1'h0;
    end
    if (isRead) begin
      state_next.opFirst = SBSC_OP_READ;
      state_next.firstData = rdLookup;
    end else if (isWrite) begin
      state_next.opFirst = SBSC_OP_WRITE;
    end else if (deselCyc) begin
      state_next.opFirst = SBSC_OP_DESEL;
    end else begin
      state_next.opFirst = SBSC_OP_IDLE;
    end
    state_next.rdSecond = (state_reg.opFirst == SBSC_OP_READ);
    state_next.secondData = state_reg.firstData;
  end

  // State register; the array itself is not reset.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  // Open straps settle high through the pull resistors: pipelined, interleaved, single.
  assign flowMode = !flowthruStrapN;
  assign dualDeselectMode = !singleDeselectStrap;

  // Drive window. Single deselect cuts the pipelined read one stage early.
  always_comb begin
    case (state_reg.opFirst)
      SBSC_OP_READ: begin
        driveWindow = flowMode || state_reg.rdSecond;
      end
      SBSC_OP_DESEL: begin
        driveWindow = !flowMode && state_reg.rdSecond && dualDeselectMode;
      end
      SBSC_OP_WRITE, SBSC_OP_IDLE: begin
        driveWindow = !flowMode && state_reg.rdSecond;
      end
      default: begin
        driveWindow = 1'h0;
      end
    endcase
  end

  // Output enable and sleep gate the pins with no clock, so a bus turn-round is immediate.
  assign dataOe = driveWindow && !outEnableN && !sleepRequest;
  assign dataOut = flowMode ? state_reg.firstData : state_reg.secondData;

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  // Read data path.
  a_flow_read_data: assert property (
    isRead ##1 flowMode |-> dataOut == $past(rdLookup))
    else $error("Flow-through read data does not match the addressed word.");

  a_pipe_read_data: assert property (
    isRead ##1 !flowMode ##1 !flowMode |-> dataOut == $past(rdLookup, 2))
    else $error("Pipelined read data does not match the addressed word.");

  a_pipe_read_late: assert property (
    (state_reg.opFirst != SBSC_OP_READ) && !state_reg.rdSecond && isRead
      ##1 (!flowMode && !outEnableN && !sleepRequest) |-> !dataOe)
    else $error("Pipelined read drove the pins one clock too early.");

  a_async_drive_gate: assert property (
    dataOe |-> !outEnableN && !sleepRequest)
    else $error("Data pins driven without output enable or during sleep.");

  // Flow-through reads drive in the first cycle after capture.
  a_flow_read_drive: assert property (
    flowMode && isRead ##1 (flowMode && !outEnableN && !sleepRequest) |-> dataOe)
    else $error("Flow-through read did not drive the pins in the next cycle.");

  // Pipelined reads drive in the second cycle unless a deselect cut them.
  a_pipe_read_drive: assert property (
    !flowMode && isRead ##1 (!flowMode && !deselCyc)
      ##1 (!flowMode && !outEnableN && !sleepRequest) |-> dataOe)
    else $error("Pipelined read did not drive the pins in its second cycle.");

  // Sleep freezes the core: no access is taken and the burst context holds.
  a_sleep_no_access: assert property (
    sleepRequest |-> !isRead && !isWrite)
    else $error("An access was taken while sleep was requested.");

  a_sleep_holds_burst: assert property (
    sleepRequest |=> state_reg.active == $past(state_reg.active))
    else $error("Burst context changed during sleep.");

  // Either strobe starts a cycle; a deselect ends the burst for good.
  a_deselect_ends: assert property (
    deselCyc |=> !state_reg.active)
    else $error("Deselect did not end the burst.");

  a_proc_start_read: assert property (
    selStart && !procAddrStrobeN |-> isRead)
    else $error("Processor strobe start was not taken as a read.");

  a_ctrl_start_active: assert property (
    selStart && procAddrStrobeN |=> state_reg.active)
    else $error("Controller strobe start did not open a burst.");

  // Deselect timing.
  a_single_deselect_off: assert property (
    deselCyc && singleDeselectStrap |=> !dataOe)
    else $error("Single deselect left the outputs on after capture.");

  a_dual_deselect_hold: assert property (
    !flowMode && !singleDeselectStrap && isRead ##1 deselCyc
      |=> ((!outEnableN && !sleepRequest && !flowMode && !singleDeselectStrap) -> dataOe)
      ##1 !dataOe)
    else $error("Dual deselect did not hold the outputs exactly one cycle.");

  // Write controls.
  a_global_write_all: assert property (
    contCyc && !allLanesWriteN |-> isWrite && wrLanes == '1)
    else $error("All-lanes write did not select every lane.");

  a_lane_write_gate: assert property (
    allLanesWriteN && laneWriteEnableN |-> !isWrite)
    else $error("Lane write happened without the lane write enable.");

  a_write_lands: assert property (
    isWrite && wrLanes[0] |=> memArray[$past(effAddr)][LANE_W-1:0] == $past(laneZeroIn))
    else $error("Write data not in the array after the capturing edge.");

  // Burst addressing.
  a_burst_load: assert property (
    selStart ##1 (contCyc && burstStepN) |-> effAddr == $past(addr))
    else $error("Burst did not start from the loaded address.");

  a_burst_hold: assert property (
    $past(isRead || isWrite) && contCyc && burstStepN |-> effAddr == $past(effAddr))
    else $error("Burst address moved without the step input.");

  a_linear_step: assert property (
    $past(isRead || isWrite) && stepCyc && !linearOrderStrapN |-> effLow == $past(effLow) + 2'h1)
    else $error("Linear burst did not step by one modulo four.");

  a_interleave_first: assert property (
    $past(selStart) && stepCyc && linearOrderStrapN |-> effLow == ($past(effLow) ^ 2'h1))
    else $error("Interleaved burst second address is not start XOR one.");

  a_fresh_address: assert property (
    selStart ##1 selStart |-> effAddr == addr && $past(effAddr) == $past(addr))
    else $error("Back-to-back start did not use the fresh pin address.");

  // Main scenarios.
  c_pipe_read: cover property (isRead ##1 !flowMode ##1 dataOe);
  c_flow_read: cover property (isRead ##1 (flowMode && dataOe));
  c_full_burst: cover property (selStart ##1 stepCyc ##1 stepCyc ##1 stepCyc);
  c_dual_deselect: cover property (isRead ##1 (deselCyc && !singleDeselectStrap) ##1 dataOe);
  c_single_deselect: cover property (isRead ##1 (deselCyc && singleDeselectStrap));

endmodule

`default_nettype wire

// ---- common/sbsc_pkg.sv ----
// Constants, types and helper functions shared by the synchronous burst SRAM core files.
// Assumes one clock in every module that imports it, and an asynchronous, active-high reset in the core modules.
//
// Overview of operation
// - Host controls are captured only on the rising clock edge.
// - Output enable and sleep request act at once, without a clock edge.
// - Either address strobe starts a new burst cycle.
// - A 2-bit burst counter loads from the external address at burst start.
// - Burst addresses step internally, only in cycles with the step input asserted.
// - The linear order strap picks linear or interleaved stepping.
// - A fresh external address may be taken every cycle at full speed.
// - Flow-through strap low sends read data around the output register.
// - Flow-through strap high sends read data through the output register.
// - Single deselect turns outputs off right after the deselect is captured.
// - Dual deselect keeps pipelined read outputs one more cycle, then turns them off.
// - The deselect strap level picks single or dual deselect behaviour.
// - Byte lanes write only when selected and the lane write enable is asserted.
// - The all-lanes write input writes every lane regardless of lane controls.
// - Writes complete internally within the capturing clock edge.
// - Floating straps mean single deselect, interleaved order, pipelined reads.

`default_nettype none

package sbsc_pkg;

  // Burst counter shape and its values after reset.
  localparam int BURST_W = 2;
  localparam logic [BURST_W-1:0] BURST_BASE_RST = 2'h0;
  localparam logic [BURST_W-1:0] BURST_COUNT_RST = 2'h0;

  // Default array shape: 2M words of two 9-bit lanes.
  localparam int LANE_W_DEF = 9;
  localparam int LANES_DEF = 2;
  localparam int ADDR_W_DEF = 21;

  // Read latency in clock edges from capture to data on the pins.
  localparam int FLOW_READ_LAT = 1;
  localparam int PIPE_READ_LAT = 2;

  // Level each strap settles to when left open; the pull resistors give it.
  localparam logic FLOWTHRU_STRAP_OPEN = 1'h1;
  localparam logic LINEAR_ORDER_STRAP_OPEN = 1'h1;
  localparam logic SINGLE_DESELECT_STRAP_OPEN = 1'h1;

  // Operation captured in the input registers in one cycle.
  typedef enum logic [1:0] {
    SBSC_OP_IDLE,
    SBSC_OP_READ,
    SBSC_OP_WRITE,
    SBSC_OP_DESEL
  } sbsc_op_t;

  // Low address bits of a burst from its start bits and its count.
  function automatic logic [BURST_W-1:0] sbscBurstLow(input logic [BURST_W-1:0] base,
                                                      input logic [BURST_W-1:0] count,
                                                      input logic linear);
    return linear ? (base + count) : (base ^ count);
  endfunction

endpackage

`default_nettype wire

// ---- common/sbsc_burst_if.sv ----
// Interface between the SRAM core control and its burst address counter.
// Assumes both ends run on the same clock; all signals are single-cycle levels.

`default_nettype none

interface sbsc_burst_if;
  import sbsc_pkg::*;
  logic load;
  logic step;
  logic [BURST_W-1:0] loadLow;
  logic linear;
  logic [BURST_W-1:0] low;

  modport ctrl (output load, output step, output loadLow, output linear, input low);
  modport cnt (input load, input step, input loadLow, input linear, output low);
endinterface

`default_nettype wire

// ---- core/sbsc_burst_counter.sv ----
// Two-bit burst address counter with linear and interleaved order.
// Assumes load and step are never both acted on; load takes priority.

`default_nettype none

module sbsc_burst_counter
  import sbsc_pkg::*;
(
  input wire logic clock, // System clock.
  input wire logic rst, // Asynchronous reset, active high.
  sbsc_burst_if.cnt burst // Load, step and address from the core.
);

  typedef struct packed {
    logic [BURST_W-1:0] base;
    logic [BURST_W-1:0] count;
  } sbsc_cnt_state_t;

  sbsc_cnt_state_t state_reg;
  sbsc_cnt_state_t state_next;

  // The low bits for this cycle come from the next state, so a step is seen at once.
  always_comb begin
    state_next = state_reg;
    if (burst.load) begin
      state_next.base = burst.loadLow;
      state_next.count = BURST_COUNT_RST;
    end else if (burst.step) begin
      state_next.count = state_reg.count + 2'h1;
    end
    burst.low = sbscBurstLow(state_next.base, state_next.count, burst.linear);
  end

  // State register.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_reg <= {BURST_BASE_RST, BURST_COUNT_RST};
    end else begin
      state_reg <= state_next;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  a_count_wrap: assert property (
    burst.step && !burst.load && state_reg.count == 2'h3 |=> state_reg.count == 2'h0)
    else $error("Burst count did not wrap after four locations.");

endmodule

`default_nettype wire

// ---- test/sbsc_host_model.sv ----
// Host side of the shared data wire between a memory controller and the SRAM core.
// Assumes the bench decides when the host offers write data; the wire has no pull.

`default_nettype none

module sbsc_host_model
  import sbsc_pkg::*;
#(
  parameter int DW = LANE_W_DEF * LANES_DEF
) (
  input wire logic clock, // System clock.
  input wire logic [DW-1:0] hostData, // Write data offered by the host.
  input wire logic hostOe, // High while the host drives the wire.
  input wire logic [DW-1:0] dataOut, // Core data toward the wire.
  input wire logic dataOe, // High while the core drives the wire.
  output logic [DW-1:0] wireData, // Resolved wire level.
  output logic clash // High when both parties drive at once.
);
  logic [DW-1:0] lastWire_reg;

  // A released wire shows the inverse of its last level, so stale data never looks valid.
  always_comb begin
    clash = dataOe && hostOe;
    if (clash) begin
      wireData = 'x;
    end else if (dataOe) begin
      wireData = dataOut;
    end else if (hostOe) begin
      wireData = hostData;
    end else begin
      wireData = ~lastWire_reg;
    end
  end

  // Remember the last level seen on the wire.
  always_ff @(posedge clock) begin
    lastWire_reg <= wireData;
  end
endmodule

`default_nettype wire

// ---- test/sbsc_sram_core_tb.sv ----
// Self-checking bench for the burst SRAM core: host cycles against a cycle model.
// Assumes a small array (6 address bits) and all strap settings tried after a reset each.

`default_nettype none

module sbsc_sram_core_tb
  import sbsc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int AW = 6;
  localparam int DW = LANE_W_DEF * LANES_DEF;
  logic clock = 0, rst = 1, sleep = 0, oeN = 0, hostOe = 0, rndOe = 0;
  logic pS = 1, cS = 1, csN = 1, stepN = 1, gwN = 1, bweN = 1, ftN = 1, lboN = 1, single_deselect_strap = 1;
  logic [LANES_DEF-1:0] bxN = '1;
  logic [AW-1:0] addr = '0, base, a;
  logic [DW-1:0] hostData = '0, dataIn, dataOut, s1Dat, s2Dat;
  logic dataOe, clash, act, s1Rd, s1Des, s2Rd;
  logic [1:0] cnt;
  logic [DW-1:0] mem [2**AW];
  int nFail = 0, cmpCount = 0;

  always #12.5 clock = ~clock;

  sbsc_sram_core #(.ADDR_W(AW)) sbsc_sram_core_i (
    .clock(clock), .rst(rst), .addr(addr), .dataIn(dataIn), .dataOut(dataOut),
    .dataOe(dataOe), .chipSelectN(csN), .procAddrStrobeN(pS), .ctrlAddrStrobeN(cS),
    .burstStepN(stepN), .laneWriteN(bxN), .laneWriteEnableN(bweN), .allLanesWriteN(gwN),
    .outEnableN(oeN), .sleepRequest(sleep), .flowthruStrapN(ftN),
    .linearOrderStrapN(lboN), .singleDeselectStrap(single_deselect_strap));

  sbsc_host_model #(.DW(DW)) sbsc_host_model_i (
    .clock(clock), .hostData(hostData), .hostOe(hostOe), .dataOut(dataOut),
    .dataOe(dataOe), .wireData(dataIn), .clash(clash));

  task automatic check(input string nm, input logic [DW-1:0] seen, input logic [DW-1:0] exp);
    cmpCount++;
    if (seen !== exp) begin
      nFail++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Lanes a write touches: the all-lanes input wins over the gated lane selects.
  function automatic logic [DW-1:0] wr_mask(input logic [3:0] w);
    logic [DW-1:0] m;
    m = '0;
    for (int i = 0; i < LANES_DEF; i++) begin
      if (!w[3] || (!w[2] && !w[i])) m[i*LANE_W_DEF +: LANE_W_DEF] = '1;
    end
    return m;
  endfunction

  // Reference model of one taken edge, fed with the levels the core samples there.
  task automatic model_edge();
    logic [DW-1:0] m;
    logic wr;
    m = wr_mask({gwN, bweN, bxN});
    a = addr;
    wr = 0;
    s2Rd = s1Rd;
    s2Dat = s1Dat;
    s1Rd = 0;
    s1Des = 0;
    if (!pS || !cS) begin
      s1Des = csN;
      act = !csN;
      base = addr;
      cnt = 0;
      s1Rd = !csN && (!pS || m == '0);
      wr = !csN && pS && m != '0;
    end else if (act) begin
      if (!stepN) cnt = cnt + 2'h1;
      a = {base[AW-1:2], lboN ? base[1:0] ^ cnt : base[1:0] + cnt};
      s1Rd = m == '0;
      wr = m != '0;
    end
    if (wr) mem[a] = (mem[a] & ~m) | (hostData & m);
    s1Dat = mem[a];
  endtask

  // One host cycle: the edge takes the old levels, then the new ones follow by NBA.
  task automatic cyc(input logic [3:0] ctl, input logic [3:0] w, input logic [AW-1:0] ad,
                     input logic [DW-1:0] d);
    logic wh;
    logic eo;
    @(posedge clock);
    if (!sleep) model_edge();
    wh = !w[3] || (!w[2] && w[1:0] != 2'h3);
    {pS, cS, csN, stepN} <= ctl;
    {gwN, bweN, bxN} <= w;
    addr <= ad;
    hostData <= d;
    hostOe <= wh;
    oeN <= wh || (rndOe && $urandom % 8 == 0);
    #2;
    eo = !oeN && !sleep && (ftN ? s2Rd && !(single_deselect_strap && s1Des) : s1Rd);
    check("dataOe", dataOe, eo);
    if (eo) check("dataOut", dataOut, ftN ? s2Dat : s1Dat);
    check("clash", clash, 1'b0);
  endtask

  // Random class: proc deselect, proc read, ctrl start (now and then deselected), or a burst continue.
  task automatic rand_cyc();
    int k;
    k = $urandom % 8;
    cyc({k > 1, k != 2 && k != 3, k == 0 || (k == 2 && $urandom % 4 == 0), 1'($urandom)},
        {$urandom % 5 != 0, $urandom % 3 != 0, 2'($urandom)}, AW'($urandom), DW'($urandom));
  endtask

  // Pins must drop at once on output enable and sleep; a write offered in sleep is lost.
  task automatic async_test(input logic [AW-1:0] ad);
    cyc(4'h5, 4'hf, ad, '0);
    repeat (2) cyc(4'hf, 4'hf, ad, '0);
    oeN = 1;
    #1;
    check("dataOe", dataOe, 1'b0);
    oeN = 0;
    sleep = 1;
    #1;
    check("dataOe", dataOe, 1'b0);
    sleep = 0;
    repeat (2) cyc(4'h7, 4'hf, ad, '0);
    sleep = 1;
    cyc(4'h9, 4'h7, ad, ~mem[ad]);
    cyc(4'hf, 4'hf, ad, '0);
    sleep = 0;
    cyc(4'h5, 4'hf, ad, '0);
    repeat (3) cyc(4'hf, 4'hf, ad, '0);
  endtask

  // Phases over every strap setting, the last one at the open-pin levels.
  initial begin
    logic [3:0] wc [5];
    wc = '{4'h7, 4'ha, 4'h9, 4'hc, 4'h8};
    void'($urandom(67192));
    for (int p = 0; p < 9; p++) begin
      rst <= 1;
      // Idle the controls first: the array is not reset and would take a stale write.
      {pS, cS, csN, stepN} <= 4'hf;
      {gwN, bweN, bxN} <= 4'hf;
      hostOe <= 1'b0;
      rndOe = 0;
      {ftN, lboN, single_deselect_strap} <= (p == 8) ? {FLOWTHRU_STRAP_OPEN, LINEAR_ORDER_STRAP_OPEN,
                                      SINGLE_DESELECT_STRAP_OPEN} : 3'(p);
      repeat (4) @(posedge clock);
      rst <= 0;
      act = 0;
      s1Rd = 0;
      s2Rd = 0;
      s1Des = 0;
      if (p == 0) for (int i = 0; i < 2**AW; i++) cyc(4'h9, 4'h7, AW'(i), DW'($urandom));
      // Burst running past its fourth word wraps within the same four locations.
      cyc(4'h9, 4'hf, AW'($urandom), '0);
      repeat (6) cyc(4'he, 4'hf, addr, '0);
      repeat (4) cyc(4'h5, 4'hf, AW'($urandom), '0);
      cyc(4'h7, 4'hf, addr, '0);
      repeat (2) cyc(4'hf, 4'hf, addr, '0);
      foreach (wc[i]) begin
        cyc(4'h9, wc[i], AW'(i), DW'($urandom));
        cyc(4'h5, 4'hf, AW'(i), '0);
        cyc(4'hf, 4'hf, AW'(i), '0);
      end
      async_test(AW'($urandom));
      rndOe = 1;
      repeat (160) rand_cyc();
    end
    final_report();
  end

  // Cut a hang short; the whole run needs about 1900 cycles.
  initial begin
    repeat (8000) @(posedge clock);
    nFail++;
    final_report();
  end

  task automatic final_report();
    if (nFail == 0 && cmpCount > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
endmodule

`default_nettype wire
